// ===== hdl/pdc_cfg_regs.sv
// dynamic configuration registers of the pll and first dll control word
// assumes an apb master via the reconfiguration bridge; ticks synchronous
//
// Operation
// - reference divided by six-bit value feeds detector
// - each divider has read-only vco phase field
// - three-bit start delay for divider 0
// - divider 0 value in div01 bits 14:8
// - divider 1 value in div01 bits 30:24
// - divider 2 value in div23 bits 14:8
// - bit 31 cascades divider 2 into 3
// - lock after 2^count periods since slip
// - phase bit 0 enables the reference divider
// - bit 1 aligns enable to reference edge
// - initial out0 vco phase in bits 4:2
// - bit 14 high-then-low reloads vco phases
// - primary phase decode 0, pi/2, pi, 2pi
// - secondary phase decode pi/2 to 2pi
// - primary output mode decode
// - secondary output mode decode
// - bit 8 selects reference divide by four
// - bit 9 clear gives direct feedback
// - bit 9 set gives inverted feedback delay
// - apb access, power-up from nonvolatile bits
`timescale 1ns/1ps
module pdc_cfg_regs
  import pdc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CFG_TARGET_DLL,
  input wire pdc_nv_t NV_CFG,
  input wire pdc_phsel_t VCO_PHASE_SEL,
  input wire logic REF_CLK_TICK,
  input wire logic CYCLE_SLIP,
  output pdc_pll_cfg_t PLL_CFG,
  output pdc_dll_cfg_t DLL_CFG,
  output logic PFD_TICK,
  output logic PHASE_LOAD,
  output logic LOCK
);

  typedef struct packed {
    logic [31:0] ref_fb;
    logic [31:0] div01;
    logic [31:0] div23;
    logic [31:0] ctrl2;
    logic [31:0] phadj;
    logic [31:0] dll0;
    logic [31:0] rdata;
    logic slverr;
    logic refdiv_run;
    logic [5:0] refcnt;
    logic pfd;
    logic load;
  } pdc_state_t;

  pdc_state_t st_ff;
  pdc_state_t nxt_st;

  // primary phase in pi/2 units
  function automatic logic [2:0] dec_pphase(input logic [1:0] c);
    case (c)
      2'h0: dec_pphase = 3'h0;
      2'h1: dec_pphase = 3'h1;
      2'h2: dec_pphase = 3'h2;
      default: dec_pphase = 3'h4;
    endcase
  endfunction

  // address decode, 1 when mapped
  function automatic logic mapped(input logic dll, input logic [7:0] a);
    if (dll)
      mapped = (a == PDC_OFS_DLL_CTRL0);
    else
      mapped = (a == PDC_OFS_REF_FB) || (a == PDC_OFS_DIV01) ||
        (a == PDC_OFS_DIV23) || (a == PDC_OFS_CTRL2) ||
        (a == PDC_OFS_PHADJ);
  endfunction

  logic setup;
  logic wr_en;
  logic [31:0] div01_rd;
  logic [31:0] div23_rd;
  logic [31:0] rd_mux;
  logic [5:0] refdiv_eff;
  logic lock_int;

  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE &&
    mapped(CFG_TARGET_DLL, PADDR);

  assign div01_rd = st_ff.div01 |
    (32'({VCO_PHASE_SEL.out1_vco_phase_select}) << PDC_POS_PHSEL_HI) |
    (32'({VCO_PHASE_SEL.out0_vco_phase_select}) << PDC_POS_PHSEL_LO);
  assign div23_rd = st_ff.div23 |
    (32'({VCO_PHASE_SEL.out3_vco_phase_select}) << PDC_POS_PHSEL_HI) |
    (32'({VCO_PHASE_SEL.out2_vco_phase_select}) << PDC_POS_PHSEL_LO);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (CFG_TARGET_DLL)
    begin
      if (PADDR == PDC_OFS_DLL_CTRL0)
        rd_mux = st_ff.dll0;
    end
    else
    begin
      case (PADDR)
        PDC_OFS_REF_FB: rd_mux = st_ff.ref_fb;
        PDC_OFS_DIV01: rd_mux = div01_rd;
        PDC_OFS_DIV23: rd_mux = div23_rd;
        PDC_OFS_CTRL2: rd_mux = st_ff.ctrl2;
        PDC_OFS_PHADJ: rd_mux = st_ff.phadj;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // zero is outside the legal range, treated as one
  assign refdiv_eff = (st_ff.ref_fb[PDC_POS_REFDIV +: 6] == 6'h00) ?
    6'h01 : st_ff.ref_fb[PDC_POS_REFDIV +: 6];

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pfd = 1'b0;
    nxt_st.load = 1'b0;
    if (setup)
    begin
      nxt_st.rdata = PWRITE ? 32'h0000_0000 : rd_mux;
      nxt_st.slverr = !mapped(CFG_TARGET_DLL, PADDR);
    end
    if (wr_en)
    begin
      // unwritable bits are masked off
      if (CFG_TARGET_DLL)
        nxt_st.dll0 = PWDATA & PDC_MSK_DLL0;
      else
      begin
        case (PADDR)
          PDC_OFS_REF_FB: nxt_st.ref_fb = PWDATA & PDC_MSK_REF_FB;
          PDC_OFS_DIV01: nxt_st.div01 = PWDATA & PDC_MSK_DIV01;
          PDC_OFS_DIV23: nxt_st.div23 = PWDATA & PDC_MSK_DIV23;
          PDC_OFS_CTRL2: nxt_st.ctrl2 = PWDATA & PDC_MSK_CTRL2;
          PDC_OFS_PHADJ:
          begin
            nxt_st.phadj = PWDATA & PDC_MSK_PHADJ;
            nxt_st.load = st_ff.phadj[PDC_POS_LOADPHS] &&
              !PWDATA[PDC_POS_LOADPHS];
          end
          default: nxt_st.ref_fb = st_ff.ref_fb;
        endcase
      end
    end
    if (!st_ff.phadj[PDC_POS_EDGE_SYNC] || REF_CLK_TICK)
      nxt_st.refdiv_run = st_ff.phadj[PDC_POS_SYNC_EN];
    if (!st_ff.refdiv_run)
    begin
      nxt_st.refcnt = PDC_RST_REFCNT;
      nxt_st.pfd = REF_CLK_TICK;
    end
    else if (REF_CLK_TICK)
    begin
      if (st_ff.refcnt + 6'h01 >= refdiv_eff)
      begin
        nxt_st.refcnt = PDC_RST_REFCNT;
        nxt_st.pfd = 1'b1;
      end
      else
        nxt_st.refcnt = st_ff.refcnt + 6'h01;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_ff.ref_fb <= NV_CFG.ref_fb & PDC_MSK_REF_FB;
      st_ff.div01 <= NV_CFG.div01 & PDC_MSK_DIV01;
      st_ff.div23 <= NV_CFG.div23 & PDC_MSK_DIV23;
      st_ff.ctrl2 <= NV_CFG.ctrl2 & PDC_MSK_CTRL2;
      st_ff.phadj <= NV_CFG.phadj & PDC_MSK_PHADJ;
      st_ff.dll0 <= NV_CFG.dll0 & PDC_MSK_DLL0;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.slverr <= 1'b0;
      st_ff.refdiv_run <= 1'b0;
      st_ff.refcnt <= PDC_RST_REFCNT;
      st_ff.pfd <= 1'b0;
      st_ff.load <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign PREADY = 1'b1;
  assign PRDATA = st_ff.rdata;
  assign PSLVERR = PSEL && PENABLE && st_ff.slverr;
  assign PFD_TICK = st_ff.pfd;
  assign PHASE_LOAD = st_ff.load;

  always_comb
  begin
    PLL_CFG.ref_divide_value = st_ff.ref_fb[PDC_POS_REFDIV +: 6];
    PLL_CFG.out0_start_delay = st_ff.div01[PDC_POS_START +: 3];
    PLL_CFG.out0_divide_value = st_ff.div01[PDC_POS_DIV_LO +: 7];
    PLL_CFG.out1_divide_value = st_ff.div01[PDC_POS_DIV_HI +: 7];
    PLL_CFG.out2_divide_value = st_ff.div23[PDC_POS_DIV_LO +: 7];
    PLL_CFG.out3_cascade_select = st_ff.div23[PDC_POS_CASCADE];
    PLL_CFG.lock_count_exponent = st_ff.ctrl2[PDC_POS_LOCK_COUNT_EXPONENT +: 4];
    PLL_CFG.out0_initial_phase = st_ff.phadj[PDC_POS_PHSINIT +: 3];
    DLL_CFG.primary_phase =
      dec_pphase(st_ff.dll0[PDC_POS_PHASE_P +: 2]);
    DLL_CFG.secondary_phase =
      {1'b0, st_ff.dll0[PDC_POS_PHASE_S +: 2]} + 3'h1;
    DLL_CFG.primary_mode =
      pdc_pmode_t'(st_ff.dll0[PDC_POS_SEL_P +: 2]);
    DLL_CFG.secondary_mode =
      pdc_smode_t'(st_ff.dll0[PDC_POS_SEL_S +: 2]);
    DLL_CFG.ref_div4 = st_ff.dll0[PDC_POS_REF_SEL];
    DLL_CFG.dll_feedback_path_select = st_ff.dll0[PDC_POS_FB_SEL];
  end

  pdc_lock_det u_lock (
    .clk(CLK),
    .reset(RESET),
    .pfd_tick(st_ff.pfd),
    .cycle_slip(CYCLE_SLIP),
    .lock_count_exponent(PLL_CFG.lock_count_exponent),
    .lock(lock_int)
  );

  assign LOCK = lock_int;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence wr_at(logic [7:0] ofs);
    wr_en && !CFG_TARGET_DLL && PADDR == ofs;
  endsequence

  chk_ro_write_ignored: assert property (
    wr_at(PDC_OFS_DIV01) |=>
      div01_rd[2:0] == VCO_PHASE_SEL.out0_vco_phase_select &&
      div01_rd[18:16] == VCO_PHASE_SEL.out1_vco_phase_select)
    else $error("read-only phase field took a write");

  chk_div0_value: assert property (
    wr_at(PDC_OFS_DIV01) |=>
      PLL_CFG.out0_divide_value == $past(PWDATA[14:8]))
    else $error("divider 0 value not taken");

  chk_div1_value: assert property (
    wr_at(PDC_OFS_DIV01) |=>
      PLL_CFG.out1_divide_value == $past(PWDATA[30:24]))
    else $error("divider 1 value not taken");

  chk_div2_cascade: assert property (
    wr_at(PDC_OFS_DIV23) |=>
      PLL_CFG.out2_divide_value == $past(PWDATA[14:8]) &&
      PLL_CFG.out3_cascade_select == $past(PWDATA[31]))
    else $error("divider 2 or cascade not taken");

  chk_phase_load: assert property (
    wr_at(PDC_OFS_PHADJ) ##0 (st_ff.phadj[14] && !PWDATA[14]) |=>
      PHASE_LOAD ##1 !PHASE_LOAD)
    else $error("phase load pulse missing");

  chk_primary_phase: assert property (
    wr_en && CFG_TARGET_DLL && PWDATA[1:0] == 2'h3 |=>
      DLL_CFG.primary_phase == 3'h4)
    else $error("primary phase 2pi misdecoded");

  chk_pfd_passthru: assert property (
    !st_ff.refdiv_run |=> PFD_TICK == $past(REF_CLK_TICK))
    else $error("disabled reference divider did not pass through");

  chk_edge_sync: assert property (
    st_ff.phadj[1] && !REF_CLK_TICK |=> $stable(st_ff.refdiv_run))
    else $error("divider enable changed off a reference edge");

  chk_refdiv_period: assert property (
    st_ff.refdiv_run && st_ff.refcnt == refdiv_eff - 6'h01 &&
      REF_CLK_TICK |=> PFD_TICK && st_ff.refcnt == 6'h00)
    else $error("reference divider period wrong");

endmodule

// ===== hdl/pdc_lock_det.sv
// lock detector: counts phase-detector periods since the last slip
// assumes pfd ticks are one-cycle enables on the system clock
`timescale 1ns/1ps
module pdc_lock_det
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pfd_tick,
  input wire logic cycle_slip,
  input wire logic [3:0] lock_count_exponent,
  output logic lock
);

  typedef struct packed {
    pdc_lock_st_t st;
    logic [15:0] cnt;
  } pdc_lk_state_t;

  pdc_lk_state_t st_ff;
  pdc_lk_state_t nxt_st;
  logic [16:0] target;

  assign target = 17'h0_0001 << lock_count_exponent;

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff.st)
      PDC_LK_HUNT:
      begin
        if (cycle_slip)
        begin
          nxt_st.cnt = PDC_RST_LOCK_COUNT_EXPONENT;
        end
        else if (pfd_tick)
        begin
          if ({1'b0, st_ff.cnt} + 17'h0_0001 >= target)
          begin
            nxt_st.st = PDC_LK_LOCKED;
          end
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
      end
      PDC_LK_LOCKED:
      begin
        if (cycle_slip)
        begin
          nxt_st.st = PDC_LK_HUNT;
          nxt_st.cnt = PDC_RST_LOCK_COUNT_EXPONENT;
        end
      end
      default:
      begin
        nxt_st.st = PDC_LK_HUNT;
        nxt_st.cnt = PDC_RST_LOCK_COUNT_EXPONENT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_ff.st <= PDC_LK_HUNT;
      st_ff.cnt <= PDC_RST_LOCK_COUNT_EXPONENT;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign lock = (st_ff.st == PDC_LK_LOCKED);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_lock_count_reached: assert property (
    $rose(lock) |-> ({1'b0, $past(st_ff.cnt)} + 17'h0_0001 >= target))
    else $error("lock rose before the period count was reached");

  chk_slip_drops_lock: assert property (
    cycle_slip |=> !lock ##0 (st_ff.cnt == 16'h0000))
    else $error("lock held across a cycle slip");

endmodule

// ===== hdl/pdc_pkg.sv
// package for the clock conditioning dynamic configuration registers
// assumes a single 125 MHz clock and a synchronous active-high reset
package pdc_pkg;

  // byte offsets, pll space
  localparam logic [7:0] PDC_OFS_REF_FB = 8'h08;
  localparam logic [7:0] PDC_OFS_DIV01 = 8'h10;
  localparam logic [7:0] PDC_OFS_DIV23 = 8'h14;
  localparam logic [7:0] PDC_OFS_CTRL2 = 8'h18;
  localparam logic [7:0] PDC_OFS_PHADJ = 8'h20;
  // byte offsets, dll space
  localparam logic [7:0] PDC_OFS_DLL_CTRL0 = 8'h00;

  // writable bits of each register
  localparam logic [31:0] PDC_MSK_REF_FB = 32'h0000_3F00;
  localparam logic [31:0] PDC_MSK_DIV01 = 32'h7F00_7F38;
  localparam logic [31:0] PDC_MSK_DIV23 = 32'h8000_7F00;
  localparam logic [31:0] PDC_MSK_CTRL2 = 32'h0000_1E00;
  localparam logic [31:0] PDC_MSK_PHADJ = 32'h0000_401F;
  localparam logic [31:0] PDC_MSK_DLL0 = 32'h0000_03FF;

  // field positions
  localparam int PDC_POS_REFDIV = 8;
  localparam int PDC_POS_PHSEL_LO = 0;
  localparam int PDC_POS_PHSEL_HI = 16;
  localparam int PDC_POS_START = 3;
  localparam int PDC_POS_DIV_LO = 8;
  localparam int PDC_POS_DIV_HI = 24;
  localparam int PDC_POS_CASCADE = 31;
  localparam int PDC_POS_LOCK_COUNT_EXPONENT = 9;
  localparam int PDC_POS_SYNC_EN = 0;
  localparam int PDC_POS_EDGE_SYNC = 1;
  localparam int PDC_POS_PHSINIT = 2;
  localparam int PDC_POS_LOADPHS = 14;
  localparam int PDC_POS_PHASE_P = 0;
  localparam int PDC_POS_PHASE_S = 2;
  localparam int PDC_POS_SEL_P = 4;
  localparam int PDC_POS_SEL_S = 6;
  localparam int PDC_POS_REF_SEL = 8;
  localparam int PDC_POS_FB_SEL = 9;

  // reset values of internal state
  localparam logic [5:0] PDC_RST_REFCNT = 6'h00;
  localparam logic [15:0] PDC_RST_LOCK_COUNT_EXPONENT = 16'h0000;

  // dll primary output mode
  typedef enum logic [1:0] {
    PDC_PM_NORMAL = 2'h0,
    PDC_PM_DUMMY = 2'h1,
    PDC_PM_DUTY50 = 2'h2,
    PDC_PM_DUTY50_INV = 2'h3
  } pdc_pmode_t;

  // dll secondary output mode
  typedef enum logic [1:0] {
    PDC_SM_NORMAL = 2'h0,
    PDC_SM_DIV2 = 2'h1,
    PDC_SM_DIV4 = 2'h2,
    PDC_SM_DUTY50 = 2'h3
  } pdc_smode_t;

  // lock detector states
  typedef enum logic [1:0] {
    PDC_LK_HUNT = 2'b01,
    PDC_LK_LOCKED = 2'b10
  } pdc_lock_st_t;

  // settings handed to the pll core
  typedef struct packed {
    logic [5:0] ref_divide_value;
    logic [2:0] out0_start_delay;
    logic [6:0] out0_divide_value;
    logic [6:0] out1_divide_value;
    logic [6:0] out2_divide_value;
    logic out3_cascade_select;
    logic [3:0] lock_count_exponent;
    logic [2:0] out0_initial_phase;
  } pdc_pll_cfg_t;

  // decoded dll settings; phases in units of pi/2
  typedef struct packed {
    logic [2:0] primary_phase;
    logic [2:0] secondary_phase;
    pdc_pmode_t primary_mode;
    pdc_smode_t secondary_mode;
    logic ref_div4;
    logic dll_feedback_path_select;
  } pdc_dll_cfg_t;

  // phase selections reported by the vco
  typedef struct packed {
    logic [2:0] out3_vco_phase_select;
    logic [2:0] out2_vco_phase_select;
    logic [2:0] out1_vco_phase_select;
    logic [2:0] out0_vco_phase_select;
  } pdc_phsel_t;

  // power-up contents of the volatile registers
  typedef struct packed {
    logic [31:0] ref_fb;
    logic [31:0] div01;
    logic [31:0] div23;
    logic [31:0] ctrl2;
    logic [31:0] phadj;
    logic [31:0] dll0;
  } pdc_nv_t;

endpackage

// ===== verif/pdc_apb_master.sv
// apb master model facing the configuration registers
// assumes one transfer at a time, tasks called from the testbench
`timescale 1ns/1ps
module pdc_apb_master (
  input wire logic CLK,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA,
  output logic DLL_SEL,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  initial
  begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    DLL_SEL = 1'b0;
  end

  // setup, access, hold until ready; released lines show inverted data
  task automatic xfer(input logic dll, input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge CLK);
    #1;
    DLL_SEL = dll;
    PSEL = 1'b1;
    PENABLE = 1'b0;
    PWRITE = wr;
    PADDR = a;
    PWDATA = d;
    @(posedge CLK);
    #1;
    PENABLE = 1'b1;
    n = 0;
    do
      @(posedge CLK);
    while (PREADY !== 1'b1 && ++n < 16);
    q = PRDATA;
    // unknown error flag when ready never came
    e = (PREADY === 1'b1) ? PSLVERR : 1'bx;
    #1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PADDR = ~a;
    PWDATA = ~d;
  endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench for the dynamic configuration registers
// assumes an apb master model and register images kept in the bench
`timescale 1ns/1ps
module testbench
  import pdc_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, dll, tick, slip;
  logic pready, pslverr, pfd, pld, lock, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  pdc_nv_t nv;
  pdc_phsel_t ph;
  pdc_pll_cfg_t pcfg;
  pdc_dll_cfg_t dcfg;
  int n_mismatch, n_checks, n_pfd, n_pld, n0;
  logic [31:0] mdl [6];
  localparam logic [7:0] OFS [6] = '{PDC_OFS_REF_FB, PDC_OFS_DIV01,
    PDC_OFS_DIV23, PDC_OFS_CTRL2, PDC_OFS_PHADJ, PDC_OFS_DLL_CTRL0};
  localparam logic [31:0] MSK [6] = '{PDC_MSK_REF_FB, PDC_MSK_DIV01,
    PDC_MSK_DIV23, PDC_MSK_CTRL2, PDC_MSK_PHADJ, PDC_MSK_DLL0};

  pdc_cfg_regs dut (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CFG_TARGET_DLL(dll), .NV_CFG(nv), .VCO_PHASE_SEL(ph),
    .REF_CLK_TICK(tick), .CYCLE_SLIP(slip), .PLL_CFG(pcfg),
    .DLL_CFG(dcfg), .PFD_TICK(pfd), .PHASE_LOAD(pld), .LOCK(lock));

  pdc_apb_master m (.CLK(clk), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .DLL_SEL(dll),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pulse counters for the one-cycle outputs
  always @(posedge clk)
  begin
    if (pfd === 1'b1) n_pfd++;
    if (pld === 1'b1) n_pld++;
  end

  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // keep divide fields inside their legal range
  function automatic logic [31:0] fix(int i, logic [31:0] d);
    logic [31:0] r;
    r = d & MSK[i];
    if (i == 0 && r[13:8] == 6'h00) r[8] = 1'b1;
    if (i == 1 && r[14:8] == 7'h00) r[8] = 1'b1;
    if (i == 1 && r[30:24] == 7'h00) r[24] = 1'b1;
    if (i == 2 && r[14:8] == 7'h00) r[8] = 1'b1;
    return r;
  endfunction

  function automatic logic [31:0] rd_exp(int i);
    logic [31:0] r;
    r = mdl[i];
    if (i == 1) r = r | {13'h0000, ph.out1_vco_phase_select, 13'h0000,
      ph.out0_vco_phase_select};
    if (i == 2) r = r | {13'h0000, ph.out3_vco_phase_select, 13'h0000,
      ph.out2_vco_phase_select};
    return r;
  endfunction

  task automatic wr(int i, logic [31:0] d);
    m.xfer(i == 5, 1'b1, OFS[i], d, q, e);
    mdl[i] = d & MSK[i];
    chk("write error", 1'b0, e);
  endtask

  task automatic rdchk(int i);
    m.xfer(i == 5, 1'b0, OFS[i], 32'h0000_0000, q, e);
    chk("read data", rd_exp(i), q);
    chk("read error", 1'b0, e);
  endtask

  task automatic cfgchk;
    pdc_pll_cfg_t ep;
    pdc_dll_cfg_t ed;
    logic [2:0] pp [4];
    logic [2:0] sp [4];
    pp = '{3'h0, 3'h1, 3'h2, 3'h4};
    sp = '{3'h1, 3'h2, 3'h3, 3'h4};
    ep.ref_divide_value = mdl[0][13:8];
    ep.out0_start_delay = mdl[1][5:3];
    ep.out0_divide_value = mdl[1][14:8];
    ep.out1_divide_value = mdl[1][30:24];
    ep.out2_divide_value = mdl[2][14:8];
    ep.out3_cascade_select = mdl[2][31];
    ep.lock_count_exponent = mdl[3][12:9];
    ep.out0_initial_phase = mdl[4][4:2];
    ed.primary_phase = pp[mdl[5][1:0]];
    ed.secondary_phase = sp[mdl[5][3:2]];
    ed.primary_mode = pdc_pmode_t'(mdl[5][5:4]);
    ed.secondary_mode = pdc_smode_t'(mdl[5][7:6]);
    ed.ref_div4 = mdl[5][8];
    ed.dll_feedback_path_select = mdl[5][9];
    @(posedge clk);
    #1;
    chk("pll cfg", ep, pcfg);
    chk("dll cfg", ed, dcfg);
  endtask

  task automatic ticks(int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      tick = 1'b1;
      @(posedge clk);
      #1;
      tick = 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic slip_pulse;
    @(posedge clk);
    #1;
    slip = 1'b1;
    @(posedge clk);
    #1;
    slip = 1'b0;
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(8 * 20000);
    n_mismatch++;
    end_sim;
  end

  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    n_pfd = 0;
    n_pld = 0;
    reset = 1'b1;
    tick = 1'b0;
    slip = 1'b0;
    void'($urandom(32'h0000_c3ba));
    for (int i = 0; i < 6; i++) mdl[i] = fix(i, $urandom());
    nv = {mdl[0], mdl[1], mdl[2], mdl[3], mdl[4], mdl[5]};
    ph = 12'($urandom());
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 6; i++) rdchk(i);
    cfgchk;
    // random words, read-only phase fields written too
    repeat (4)
    begin
      ph = 12'($urandom());
      for (int i = 0; i < 6; i++)
        wr(i, fix(i, $urandom()) | ((i == 1 || i == 2) ? 32'h0007_0007
          : 32'h0000_0000));
      for (int i = 0; i < 6; i++) rdchk(i);
      cfgchk;
    end
    // every dll code of every field
    for (int k = 0; k < 4; k++)
    begin
      wr(5, {22'h00_0000, 2'(k), 2'(k), 2'(k), 2'(k), 2'(k)});
      cfgchk;
    end
    m.xfer(1'b0, 1'b0, 8'h0C, 32'h0000_0000, q, e);
    chk("unmapped error", 1'b1, e);
    chk("unmapped data", 32'h0000_0000, q);
    m.xfer(1'b1, 1'b0, 8'h04, 32'h0000_0000, q, e);
    chk("unmapped dll", 1'b1, e);
    // common enable low passes every reference tick
    wr(4, 32'h0000_0000);
    n0 = n_pfd;
    ticks(10);
    chk("pfd undivided", 10, n_pfd - n0);
    wr(0, 32'h0000_0300);
    wr(4, 32'h0000_0001);
    repeat (3) @(posedge clk);
    n0 = n_pfd;
    ticks(12);
    chk("pfd divided", 4, n_pfd - n0);
    // lock after 2^exp pfd periods since the slip
    wr(4, 32'h0000_0000);
    for (int x = 0; x < 4; x++)
    begin
      wr(3, 32'(x) << 9);
      slip_pulse;
      ticks((1 << x) - 1);
      chk("lock early", 1'b0, lock);
      ticks(1);
      chk("lock", 1'b1, lock);
    end
    // phase reload only on high then low
    n0 = n_pld;
    wr(4, 32'h0000_4000);
    wr(4, 32'h0000_4000);
    wr(4, 32'h0000_0000);
    wr(4, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk("phase load", 1, n_pld - n0);
    // enable held off until a reference edge, divide by 3 after it
    wr(4, 32'h0000_0003);
    repeat (3) @(posedge clk);
    n0 = n_pfd;
    ticks(7);
    chk("pfd edge sync", 3, n_pfd - n0);
    end_sim;
  end
endmodule
